// File: rtl/mifu_irq_unit.v
// interrupt flag and enable unit with apb register access and core vector handshake
// Contract
// [R1] Pin-one edge field at select bits 3:2 decodes off, rising, falling, both.
// [R2] Pin-zero edge field at select bits 1:0 decodes the same way for the pin-zero flag.
// [R3] Bit 0 of primary control A is the global enable and blocks every delivery when low; here it gates irq_req but not irq_out.
// [R4] Flags read 1 when pending, enables read 1 when enabled.
// [R5] Primary A holds time-base-zero, pin-one, pin-zero flags at 6:4, enables at 3:1, bit 7 zero.
// [R6] Primary B holds group two, one, zero flags at 7:5, time-base-one flag at 4, enables at 3:0.
// [R7] Primary C holds conversion-done flag at bit 4 and enable at bit 0, others zero.
// [R8] Group A holds periodic and standard-zero compare flags at 7:4 and enables at 3:0.
// [R9] Control is three primary registers, three group registers and one edge select register.
// [R10] Unimplemented bits read zero and ignore writes.
// [R11] Sources are two pins plus timers, time bases, low-voltage, storage, radio and converter.
// [R12] Group C holds radio edge, storage and low-voltage flags at 6:4 and enables at 2:0.
// [R13] Flags set regardless of enable; a vector needs flag, enable and global enable.
// [R14] Servicing clears the global enable while new requests still latch.
// [R15] A full return stack holds off acknowledgement until it is no longer full.
// [R16] A group flag sets when any of its sub-flags is set with its sub-enable set.
// [R17] All bits reset to zero and software can set and clear every flag by writing; group flags set again while an enabled sub-flag stands.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "mifu_defines.vh"
module mifu_irq_unit (
	input wire pclk, // system clock, 125 MHz
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready, always high
	output wire pslverr, // apb error on unmapped address
	input wire ext_pin_zero, // external pin zero, async
	input wire ext_pin_one, // external pin one, async
	input wire timebase_zero_evt, // time base zero overflow pulse
	input wire timebase_one_evt, // time base one overflow pulse
	input wire conv_done_evt, // a/d conversion done pulse
	input wire [3:0] group_a_evt, // ptm a, ptm p, stm0 a, stm0 p pulses
	input wire [1:0] group_b_evt, // stm1 a, stm1 p pulses
	input wire [2:0] group_c_evt, // radio edge, nvm write, low volt pulses
	input wire stack_full, // core return stack full
	output wire irq_req, // vector request to core, level
	output wire [2:0] irq_vector, // source index of the request
	input wire irq_ack, // core takes the vector, one-cycle pulse
	output wire irq_out // summary interrupt from status/enable
);
	// [R9] seven control registers
	reg [7:0] ext_edge_select;
	reg [7:0] primary_ctrl_a;
	reg [7:0] primary_ctrl_b;
	reg [7:0] primary_ctrl_c;
	reg [7:0] group_ctrl_a;
	reg [7:0] group_ctrl_b;
	reg [7:0] group_ctrl_c;
	reg [7:0] evt_status;
	reg [7:0] evt_enable;
	reg [7:0] next_pa;
	reg [7:0] next_pb;
	reg [7:0] next_pc;
	reg [7:0] next_ga;
	reg [7:0] next_gb;
	reg [7:0] next_gc;
	reg [31:0] next_rdata;
	wire p0_rise;
	wire p0_fall;
	wire p1_rise;
	wire p1_fall;
	wire pin_zero_hit;
	wire pin_one_hit;
	wire [2:0] grp_hit;
	wire [7:0] pend;
	wire [2:0] sel;
	wire wr;
	wire rd_hit;
	wire take;
	genvar k;

	// edge field decode, shared by both pins
	function edge_hit;
		input [1:0] field;
		input r;
		input f;
		begin
			case (field)
				`MIFU_EDGE_RISE: edge_hit = r;
				`MIFU_EDGE_FALL: edge_hit = f;
				`MIFU_EDGE_BOTH: edge_hit = r | f;
				default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	// keep implemented bits only: flags, enables and edge fields
	function [7:0] merge;
		input [7:0] wdata;
		input [7:0] mask;
		begin
			merge = wdata & mask;
		end
	endfunction

	// any sub-request whose sub-enable is set
	function any_req;
		input [3:0] flags;
		input [3:0] enables;
		begin
			any_req = |(flags & enables);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	mifu_pin_sync u_sync_p0 (
		.pclk(pclk),
		.presetn(presetn),
		.pin(ext_pin_zero),
		.rise(p0_rise),
		.fall(p0_fall)
	);
	mifu_pin_sync u_sync_p1 (
		.pclk(pclk),
		.presetn(presetn),
		.pin(ext_pin_one),
		.rise(p1_rise),
		.fall(p1_fall)
	);

	// [R2] pin zero edge
	assign pin_zero_hit = edge_hit(ext_edge_select[`MIFU_EDGE_P0_LSB+1:`MIFU_EDGE_P0_LSB], p0_rise, p0_fall);
	// [R1] pin one edge
	assign pin_one_hit = edge_hit(ext_edge_select[`MIFU_EDGE_P1_LSB+1:`MIFU_EDGE_P1_LSB], p1_rise, p1_fall);

	// [R16] group request per register
	// a group keeps re-setting its flag until software clears the sub-flag or its sub-enable
	assign grp_hit[0] = any_req(group_ctrl_a[7:4], group_ctrl_a[3:0]);
	assign grp_hit[1] = any_req({2'b00, group_ctrl_b[5:4]}, {2'b00, group_ctrl_b[1:0]});
	assign grp_hit[2] = any_req({1'b0, group_ctrl_c[6:4]}, {1'b0, group_ctrl_c[2:0]});

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, error on unmapped offsets
	assign wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign rd_hit = (paddr == `MIFU_OFF_EDGE) || (paddr == `MIFU_OFF_PRIA) || (paddr == `MIFU_OFF_PRIB) ||
		(paddr == `MIFU_OFF_PRIC) || (paddr == `MIFU_OFF_GRPA) || (paddr == `MIFU_OFF_GRPB) ||
		(paddr == `MIFU_OFF_GRPC) || (paddr == `MIFU_OFF_STAT) || (paddr == `MIFU_OFF_CLR) ||
		(paddr == `MIFU_OFF_IEN);
	assign pslverr = psel & penable & ~rd_hit;

	// [R10] read mux, unimplemented bits read zero
	// [R4] flags and enables read as held
	always @* begin
		next_rdata = `MIFU_RST_RDATA;
		case (paddr)
			`MIFU_OFF_EDGE: next_rdata[7:0] = ext_edge_select;
			`MIFU_OFF_PRIA: next_rdata[7:0] = primary_ctrl_a;
			`MIFU_OFF_PRIB: next_rdata[7:0] = primary_ctrl_b;
			`MIFU_OFF_PRIC: next_rdata[7:0] = primary_ctrl_c;
			`MIFU_OFF_GRPA: next_rdata[7:0] = group_ctrl_a;
			`MIFU_OFF_GRPB: next_rdata[7:0] = group_ctrl_b;
			`MIFU_OFF_GRPC: next_rdata[7:0] = group_ctrl_c;
			`MIFU_OFF_STAT: next_rdata[7:0] = evt_status;
			`MIFU_OFF_IEN: next_rdata[7:0] = evt_enable;
			default: next_rdata = `MIFU_RST_RDATA;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// read word captured in the setup phase, so prdata comes from a flop
	// with no wait state; an event landing in the access cycle shows on the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= `MIFU_RST_RDATA;
		else if (psel && !penable)
			prdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// [R13] pending sources, fixed priority: lower index wins
	assign pend[`MIFU_SRC_TB0] = primary_ctrl_a[`MIFU_BIT_TIMEBASE_ZERO_FLAG] & primary_ctrl_a[`MIFU_BIT_TIMEBASE_ZERO_ENABLE];
	assign pend[`MIFU_SRC_P0] = primary_ctrl_a[`MIFU_BIT_P0F] & primary_ctrl_a[`MIFU_BIT_P0E];
	assign pend[`MIFU_SRC_P1] = primary_ctrl_a[`MIFU_BIT_P1F] & primary_ctrl_a[`MIFU_BIT_P1E];
	assign pend[`MIFU_SRC_TB1] = primary_ctrl_b[`MIFU_BIT_TIMEBASE_ONE_FLAG] & primary_ctrl_b[`MIFU_BIT_TIMEBASE_ONE_ENABLE];

	// [R13] group vectors gated
	// group n flag and enable sit n bits above the group zero positions
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_grp_pend
			assign pend[`MIFU_SRC_G0+k] = primary_ctrl_b[`MIFU_BIT_G0F+k] & primary_ctrl_b[`MIFU_BIT_G0E+k];
		end
	endgenerate
	assign pend[`MIFU_SRC_AD] = primary_ctrl_c[`MIFU_BIT_ADF] & primary_ctrl_c[`MIFU_BIT_ADE];

	assign sel = pend[0] ? 3'h0 : pend[1] ? 3'h1 : pend[2] ? 3'h2 : pend[3] ? 3'h3 :
		pend[4] ? 3'h4 : pend[5] ? 3'h5 : pend[6] ? 3'h6 : 3'h7;

	// [R3] global gate; [R15] held off while stack is full
	assign irq_req = primary_ctrl_a[`MIFU_BIT_EMI] & (|pend) & ~stack_full;
	assign irq_vector = sel;
	assign take = irq_req & irq_ack;

	////////////////////////////////////////////////////////////////////////////////
	// next values of control registers: write, then auto-clear, then event sets win
	always @* begin
		next_pa = primary_ctrl_a;
		next_pb = primary_ctrl_b;
		next_pc = primary_ctrl_c;
		next_ga = group_ctrl_a;
		next_gb = group_ctrl_b;
		next_gc = group_ctrl_c;
		// [R17] software writes set or clear any flag
		if (wr && paddr == `MIFU_OFF_PRIA)
			next_pa = merge(pwdata[7:0], `MIFU_MASK_PRIA);
		if (wr && paddr == `MIFU_OFF_PRIB)
			next_pb = merge(pwdata[7:0], `MIFU_MASK_PRIB);
		if (wr && paddr == `MIFU_OFF_PRIC)
			next_pc = merge(pwdata[7:0], `MIFU_MASK_PRIC);
		if (wr && paddr == `MIFU_OFF_GRPA)
			next_ga = merge(pwdata[7:0], `MIFU_MASK_GRPA);
		if (wr && paddr == `MIFU_OFF_GRPB)
			next_gb = merge(pwdata[7:0], `MIFU_MASK_GRPB);
		if (wr && paddr == `MIFU_OFF_GRPC)
			next_gc = merge(pwdata[7:0], `MIFU_MASK_GRPC);
		// [R14] service clears global enable and the taken flag of a non-group source
		if (take) begin
			next_pa[`MIFU_BIT_EMI] = 1'b0;
			case (sel)
				`MIFU_SRC_TB0: next_pa[`MIFU_BIT_TIMEBASE_ZERO_FLAG] = 1'b0;
				`MIFU_SRC_P0: next_pa[`MIFU_BIT_P0F] = 1'b0;
				`MIFU_SRC_P1: next_pa[`MIFU_BIT_P1F] = 1'b0;
				`MIFU_SRC_TB1: next_pb[`MIFU_BIT_TIMEBASE_ONE_FLAG] = 1'b0;
				`MIFU_SRC_AD: next_pc[`MIFU_BIT_ADF] = 1'b0;
				default: next_pb = next_pb; // group flags are cleared by software
			endcase
		end
		// [R13] sources set flags whatever the enables
		if (timebase_zero_evt)
			next_pa[`MIFU_BIT_TIMEBASE_ZERO_FLAG] = 1'b1;
		if (pin_zero_hit)
			next_pa[`MIFU_BIT_P0F] = 1'b1;
		if (pin_one_hit)
			next_pa[`MIFU_BIT_P1F] = 1'b1;
		if (timebase_one_evt)
			next_pb[`MIFU_BIT_TIMEBASE_ONE_FLAG] = 1'b1;
		// [R16] group flags follow enabled sub-requests
		if (grp_hit[0])
			next_pb[`MIFU_BIT_G0F] = 1'b1;
		if (grp_hit[1])
			next_pb[`MIFU_BIT_G0F+1] = 1'b1;
		if (grp_hit[2])
			next_pb[`MIFU_BIT_G0F+2] = 1'b1;
		if (conv_done_evt)
			next_pc[`MIFU_BIT_ADF] = 1'b1;
		// [R8] group zero and group one sub-flags
		next_ga[7:4] = next_ga[7:4] | group_a_evt;
		next_gb[5:4] = next_gb[5:4] | group_b_evt;
		// [R12] group two sub-flags
		next_gc[6:4] = next_gc[6:4] | group_c_evt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// [R17] control registers, all zero from reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_edge_select <= `MIFU_RST_REG;
			primary_ctrl_a <= `MIFU_RST_REG;
			primary_ctrl_b <= `MIFU_RST_REG;
			primary_ctrl_c <= `MIFU_RST_REG;
			group_ctrl_a <= `MIFU_RST_REG;
			group_ctrl_b <= `MIFU_RST_REG;
			group_ctrl_c <= `MIFU_RST_REG;
		end else begin
			// [R10] upper edge bits ignore writes
			if (wr && paddr == `MIFU_OFF_EDGE)
				ext_edge_select <= merge(pwdata[7:0], `MIFU_MASK_EDGE);
			// [R5] primary a layout
			primary_ctrl_a <= next_pa;
			// [R6] primary b layout
			primary_ctrl_b <= next_pb;
			// [R7] primary c layout
			primary_ctrl_c <= next_pc;
			group_ctrl_a <= next_ga;
			group_ctrl_b <= next_gb;
			group_ctrl_c <= next_gc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky event status: bit n set when source n is taken by the core
	// set beats a clear arriving in the same cycle, so no event is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_status <= `MIFU_RST_REG;
			evt_enable <= `MIFU_RST_REG;
		end else begin
			if (wr && paddr == `MIFU_OFF_IEN)
				evt_enable <= pwdata[7:0];
			evt_status <= (evt_status & ~((wr && paddr == `MIFU_OFF_CLR) ? pwdata[7:0] : 8'h00)) |
				(take ? (8'h01 << sel) : 8'h00);
		end
	end

	// [R11] summary line for sources taken by the core
	assign irq_out = |(evt_status & evt_enable);
endmodule // mifu_irq_unit

// File: rtl/mifu_defines.vh
// register map, field positions and reset values of the interrupt flag/enable unit
`ifndef MIFU_DEFINES_VH
`define MIFU_DEFINES_VH
`define MIFU_OFF_EDGE 12'h000
`define MIFU_OFF_PRIA 12'h004
`define MIFU_OFF_PRIB 12'h008
`define MIFU_OFF_PRIC 12'h00C
`define MIFU_OFF_GRPA 12'h010
`define MIFU_OFF_GRPB 12'h014
`define MIFU_OFF_GRPC 12'h018
`define MIFU_OFF_STAT 12'h01C
`define MIFU_OFF_CLR 12'h020
`define MIFU_OFF_IEN 12'h024
`define MIFU_MASK_EDGE 8'h0F
`define MIFU_MASK_PRIA 8'h7F
`define MIFU_MASK_PRIB 8'hFF
`define MIFU_MASK_PRIC 8'h11
`define MIFU_MASK_GRPA 8'hFF
`define MIFU_MASK_GRPB 8'h33
`define MIFU_MASK_GRPC 8'h77
`define MIFU_RST_REG 8'h00
`define MIFU_BIT_EMI 0
`define MIFU_BIT_P0E 1
`define MIFU_BIT_P1E 2
`define MIFU_BIT_TIMEBASE_ZERO_ENABLE 3
`define MIFU_BIT_P0F 4
`define MIFU_BIT_P1F 5
`define MIFU_BIT_TIMEBASE_ZERO_FLAG 6
`define MIFU_BIT_ADE 0
`define MIFU_BIT_ADF 4
`define MIFU_BIT_TIMEBASE_ONE_ENABLE 0
`define MIFU_BIT_TIMEBASE_ONE_FLAG 4
`define MIFU_BIT_G0E 1
`define MIFU_BIT_G0F 5
`define MIFU_RST_RDATA 32'h00000000
`define MIFU_FLAG_LSB 4
`define MIFU_EDGE_P0_LSB 0
`define MIFU_EDGE_P1_LSB 2
`define MIFU_EDGE_OFF 2'b00
`define MIFU_EDGE_RISE 2'b01
`define MIFU_EDGE_FALL 2'b10
`define MIFU_EDGE_BOTH 2'b11
`define MIFU_SRC_TB0 3'h0
`define MIFU_SRC_P0 3'h1
`define MIFU_SRC_P1 3'h2
`define MIFU_SRC_TB1 3'h3
`define MIFU_SRC_G0 3'h4
`define MIFU_SRC_G1 3'h5
`define MIFU_SRC_G2 3'h6
`define MIFU_SRC_AD 3'h7
`endif

// File: rtl/mifu_pin_sync.v
// three-stage synchroniser with edge detection for one external pin
`timescale 1ns/100ps
module mifu_pin_sync (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire pin, // asynchronous pin level
	output wire rise, // one-cycle rising pulse
	output wire fall // one-cycle falling pulse
);
	reg s1;
	reg s2;
	reg s3;
	reg stable;

	// s1 feeds only s2; a change counts once s2 and s3 agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			stable <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				stable <= s3;
		end
	end

	assign rise = (s2 == s3) && s3 && !stable;
	assign fall = (s2 == s3) && !s3 && stable;
endmodule // mifu_pin_sync

// File: tb/mifu_core_model.sv
// behavioural cpu core that takes vector requests after a set latency
`timescale 1ns/100ps
module mifu_core_model (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire irq_req, // vector request from the unit
	input wire [2:0] irq_vector, // source index
	input wire go, // core accepts vectors
	input wire [1:0] lat, // wait before the ack
	output reg irq_ack, // one-cycle ack
	output reg [2:0] last_vec, // vector seen at the ack
	output reg [3:0] taken // acks taken
);
reg [1:0] dly;
// one ack each
// an ack only counts if the request still stands at its edge
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_ack <= 1'b0;
		last_vec <= 3'h0;
		taken <= 4'h0;
		dly <= 2'h0;
	end else if (irq_ack) begin
		irq_ack <= 1'b0;
		if (irq_req) begin
			taken <= taken + 4'h1;
			last_vec <= irq_vector;
		end
	end else if (go && irq_req) begin
		if (dly >= lat) begin
			irq_ack <= 1'b1;
			dly <= 2'h0;
		end else begin
			dly <= dly + 2'h1;
		end
	end else begin
		dly <= 2'h0;
	end
end
endmodule // mifu_core_model

// File: tb/mifu_irq_unit_properties.sv
// port-level checker for the interrupt flag/enable unit
`timescale 1ns/100ps
`include "mifu_defines.vh"
module mifu_irq_unit_properties (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb address
	input wire [31:0] pwdata, // apb write data
	input wire [31:0] prdata, // apb read data
	input wire stack_full, // core stack full
	input wire irq_req, // vector request
	input wire irq_ack, // core ack
	input wire irq_out // summary interrupt
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire rd = psel && penable && !pwrite;
wire wr = psel && penable && pwrite;
property p_stack; stack_full |-> !irq_req; endproperty
a_stack: assert property (p_stack) else $error("request while stack full");
property p_nest; irq_req && irq_ack |=> !irq_req [*2]; endproperty
a_nest: assert property (p_nest) else $error("request kept after ack");
property p_gie; wr && paddr == `MIFU_OFF_PRIA && !pwdata[0] |=> !irq_req; endproperty
a_gie: assert property (p_gie) else $error("request with global enable low");
property p_edge; rd && paddr == `MIFU_OFF_EDGE |-> prdata[31:4] == 28'h0; endproperty
a_edge: assert property (p_edge) else $error("edge select upper bits set");
property p_pria; rd && paddr == `MIFU_OFF_PRIA |-> prdata[31:7] == 25'h0; endproperty
a_pria: assert property (p_pria) else $error("primary a bit 7 set");
property p_pric; rd && paddr == `MIFU_OFF_PRIC |-> (prdata & ~32'h11) == 32'h0; endproperty
a_pric: assert property (p_pric) else $error("primary c spare bits set");
property p_grpb; rd && paddr == `MIFU_OFF_GRPB |-> (prdata & ~32'h33) == 32'h0; endproperty
a_grpb: assert property (p_grpb) else $error("group b spare bits set");
property p_rst; $rose(presetn) |-> !irq_req && !irq_out; endproperty
a_rst: assert property (p_rst) else $error("interrupt out of reset");
endmodule // mifu_irq_unit_properties
bind mifu_irq_unit mifu_irq_unit_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.stack_full(stack_full), .irq_req(irq_req), .irq_ack(irq_ack), .irq_out(irq_out));

// File: tb/mifu_irq_unit_bench.sv
// self-checking bench for the interrupt flag/enable unit
`timescale 1ns/100ps
`include "mifu_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module mifu_irq_unit_bench;
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, p0 = 0, p1 = 0;
reg tb0 = 0, tb1 = 0, ad = 0, sf = 0, go = 0, rerr;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0;
reg [3:0] ga = 0;
reg [1:0] gb = 0, lat = 0, pb;
reg [2:0] gc = 0;
reg [7:0] rdat, ev;
reg [7:0] msk [0:6];
wire [31:0] prdata;
wire pready, pslverr, irq_req, irq_ack, irq_out;
wire [2:0] irq_vector, last_vec;
wire [3:0] taken;
integer err_total = 0, checks = 0, i, n;
initial forever #4 pclk = ~pclk;
mifu_irq_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_pin_zero(p0), .ext_pin_one(p1), .timebase_zero_evt(tb0), .timebase_one_evt(tb1),
	.conv_done_evt(ad), .group_a_evt(ga), .group_b_evt(gb), .group_c_evt(gc), .stack_full(sf),
	.irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_out(irq_out));
mifu_core_model u_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector),
	.go(go), .lat(lat), .irq_ack(irq_ack), .last_vec(last_vec), .taken(taken));
////////////////////////////////////////
task stop_test; begin
	$display("checks %0d err_total %0d", checks, err_total);
	if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
end endtask
// one apb transfer; held until pready is seen at an edge
task xfer(input w, input [11:0] a, input [7:0] d); begin
	@(posedge pclk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= {24'h0, d};
	@(posedge pclk);
	penable <= 1'b1;
	n = 0;
	@(posedge pclk);
	while (pready !== 1'b1 && n < 50) begin
		n = n + 1;
		@(posedge pclk);
	end
	if (n >= 50) begin err_total++; stop_test; end
	rdat = prdata[7:0];
	rerr = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
end endtask
task wr(input [11:0] a, input [7:0] d); xfer(1'b1, a, d); endtask
task rd(input [11:0] a); xfer(1'b0, a, 8'h00); endtask
task tick(input integer k); repeat (k) @(posedge pclk); endtask
// bounded wait for the core to take t vectors
task wait_taken(input [3:0] t); begin
	n = 0;
	while (taken !== t && n < 100) begin n = n + 1; @(posedge pclk); end
	if (n >= 100) begin err_total++; stop_test; end
end endtask
initial begin
	repeat (50000) @(posedge pclk);
	err_total++;
	stop_test;
end
initial begin
	msk[0] = `MIFU_MASK_EDGE;
	msk[1] = `MIFU_MASK_PRIA;
	msk[2] = `MIFU_MASK_PRIB;
	msk[3] = `MIFU_MASK_PRIC;
	msk[4] = `MIFU_MASK_GRPA;
	msk[5] = `MIFU_MASK_GRPB;
	msk[6] = `MIFU_MASK_GRPC;
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	// reset values of every mapped word
	for (i = 0; i < 10; i++) begin
		rd({i[9:0], 2'b00});
		`CHK(rdat, 8'h00)
	end
	// an unmapped word errors and reads zero; the slave never stalls
	rd(12'h028);
	`CHK({pready, rerr, rdat}, 10'h300)
	// spare bits stay zero; every bit clears again (groups first, they refill primary b)
	for (i = 0; i < 7; i++) begin
		wr({i[9:0], 2'b00}, 8'hFF);
		rd({i[9:0], 2'b00});
		`CHK(rdat, msk[i])
	end
	for (i = 6; i >= 0; i--) begin
		wr({i[9:0], 2'b00}, 8'h00);
		rd({i[9:0], 2'b00});
		`CHK(rdat, 8'h00)
	end
	// every edge mode of both pins: a rise, then a fall
	for (i = 0; i < 8; i++) begin
		ev = (i < 4) ? {6'h0, i[1:0]} : {4'h0, i[1:0], 2'h0};
		pb = (i < 4) ? 2'b01 : 2'b10;
		wr(`MIFU_OFF_EDGE, ev);
		if (i < 4)
			p0 <= 1'b1;
		else
			p1 <= 1'b1;
		tick(8);
		rd(`MIFU_OFF_PRIA);
		`CHK(rdat[5:4], i[0] ? pb : 2'b00)
		wr(`MIFU_OFF_PRIA, 8'h00);
		p0 <= 1'b0;
		p1 <= 1'b0;
		tick(8);
		rd(`MIFU_OFF_PRIA);
		`CHK(rdat[5:4], i[1] ? pb : 2'b00)
		wr(`MIFU_OFF_PRIA, 8'h00);
	end
	wr(`MIFU_OFF_EDGE, 8'h00);
	// flag latches while disabled, then a delayed vector; stack full holds it off
	tb0 <= 1'b1;
	tick(1);
	tb0 <= 1'b0;
	rd(`MIFU_OFF_PRIA);
	`CHK(rdat, 8'h40)
	wr(`MIFU_OFF_PRIA, 8'h49);
	tick(1);
	`CHK({irq_req, irq_vector}, {1'b1, `MIFU_SRC_TB0})
	sf <= 1'b1;
	tick(2);
	`CHK(irq_req, 1'b0)
	sf <= 1'b0;
	lat <= 2'h2;
	go <= 1'b1;
	wait_taken(4'h1);
	`CHK(last_vec, `MIFU_SRC_TB0)
	ad <= 1'b1;
	tick(1);
	ad <= 1'b0;
	rd(`MIFU_OFF_PRIA);
	`CHK(rdat, 8'h08)
	rd(`MIFU_OFF_PRIC);
	`CHK(rdat, 8'h10)
	wr(`MIFU_OFF_PRIC, 8'h11);
	tick(2);
	`CHK(irq_req, 1'b0)
	lat <= 2'h0;
	wr(`MIFU_OFF_PRIA, 8'h01);
	wait_taken(4'h2);
	`CHK(last_vec, `MIFU_SRC_AD)
	rd(`MIFU_OFF_PRIC);
	`CHK(rdat, 8'h01)
	// serviced status: masked, enabled, cleared, read-only
	rd(`MIFU_OFF_STAT);
	`CHK({irq_out, rdat}, 9'h081)
	wr(`MIFU_OFF_IEN, 8'h80);
	tick(1);
	`CHK(irq_out, 1'b1)
	wr(`MIFU_OFF_CLR, 8'h80);
	wr(`MIFU_OFF_STAT, 8'hFF);
	rd(`MIFU_OFF_STAT);
	`CHK({irq_out, rdat}, 9'h001)
	rd(`MIFU_OFF_CLR);
	`CHK(rdat, 8'h00)
	// group sub-sources latch; a group flag needs a sub-enable
	ga <= 4'hF;
	gb <= 2'h3;
	gc <= 3'h7;
	tick(1);
	ga <= 4'h0;
	gb <= 2'h0;
	gc <= 3'h0;
	rd(`MIFU_OFF_GRPA);
	`CHK(rdat, 8'hF0)
	rd(`MIFU_OFF_GRPB);
	`CHK(rdat, 8'h30)
	rd(`MIFU_OFF_GRPC);
	`CHK(rdat, 8'h70)
	rd(`MIFU_OFF_PRIB);
	`CHK(rdat, 8'h00)
	wr(`MIFU_OFF_GRPC, 8'h74);
	tick(2);
	rd(`MIFU_OFF_PRIB);
	`CHK(rdat, 8'h80)
	wr(`MIFU_OFF_GRPA, 8'hF1);
	tick(2);
	rd(`MIFU_OFF_PRIB);
	`CHK(rdat, 8'hA0)
	wr(`MIFU_OFF_GRPB, 8'h31);
	tb1 <= 1'b1;
	tick(1);
	tb1 <= 1'b0;
	tick(2);
	rd(`MIFU_OFF_PRIB);
	`CHK(rdat, 8'hF0)
	stop_test;
end
endmodule // mifu_irq_unit_bench
